/* File: shared/mono_consts.svh */
// offsets, fields, reset values and codes for the mono lcd logic
`ifndef MONO_CONSTS_SVH
`define MONO_CONSTS_SVH
`define PWR_STATUS_ADDR 16'hf301
`define PWR_PRESENT_BIT 0
`define OPT_CMAP_BIT 2
`define CMAP_EN_RESET 1'b1
`define VSR_FN_WRITE_CHAR 8'h09
`define VSR_FN_SET_MODE 8'h00
`define BL_FUNC 16'h11ba
`define BL_SUB 8'h03
`define BL_SEL_ON 8'h01
`define BL_SEL_OFF 8'h00
`define MODE_COLOUR_GFX 8'h05
`define MODE_MONO_GFX 8'h04
`define MODE_RESET 8'h00
`define LED_SCROLL 3'h1
`define LED_NONE 3'h0
`endif

/* File: shared/mono_pkg.sv */
// types shared by the mono lcd logic
package mono_pkg;
  // backlight state, one-hot
  typedef enum logic [1:0] {
    BL_LIT  = 2'h1,
    BL_DARK = 2'h2
  } bl_state_t;
  typedef logic [7:0] attr_t;
  typedef logic [3:0] colour_t;
endpackage

/* File: shared/attr_if.sv */
// carrier between the top and the attribute mapper
`timescale 1ns/100ps
`default_nettype none
interface attr_if;
  logic             cmap_en;   // correction enabled
  mono_pkg::attr_t  attr_in;   // requested attribute
  mono_pkg::attr_t  attr_out;  // corrected attribute
  logic [15:0]      pix_codes; // four 4-bit colour codes
  logic [3:0]       pix_white; // one per code, 1 = white
  modport top (output cmap_en, output attr_in, output pix_codes,
               input attr_out, input pix_white);
  modport mapper (input cmap_en, input attr_in, input pix_codes,
                  output attr_out, output pix_white);
endinterface
`default_nettype wire

/* File: hdl/attr_mapper.sv */
// colour-map correction and parity to black/white
`timescale 1ns/100ps
`default_nettype none
module attr_mapper (
  attr_if.mapper m
);
  wire       fg_odd;   // foreground parity
  wire       bg_odd;   // background parity
  wire       same_par; // both odd or both even
  assign fg_odd   = m.attr_in[0];
  assign bg_odd   = m.attr_in[4];
  assign same_par = ~(fg_odd ^ bg_odd);
  // flipping bit 0 swaps parity with the nearest colour, so
  // white on blue becomes brown on blue
  assign m.attr_out = (m.cmap_en && same_par) ?
                      (m.attr_in ^ 8'h01) : m.attr_in;
  // odd codes white, even codes black, one lane per code
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pix
      assign m.pix_white[i] = m.pix_codes[4*i];
    end
  endgenerate
endmodule // attr_mapper
`default_nettype wire

/* File: hdl/mono_lcd_attribute_power_logic.sv */
// top of the black-and-white lcd attribute and power logic
`timescale 1ns/100ps
`default_nettype none
`include "mono_consts.svh"
module mono_lcd_attribute_power_logic (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // i/o channel
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  output logic             io_rvalid,
  // primary power sense, 1 = present
  input  wire logic        primary_power,
  // video option byte update
  input  wire logic        opt_wr,
  input  wire logic [7:0]  opt_wdata,
  // video service request
  input  wire logic        vsr_valid,
  input  wire logic [7:0]  vsr_func,
  input  wire logic [7:0]  vsr_mode,
  input  wire logic [7:0]  vsr_char,
  input  wire logic [7:0]  vsr_attr,
  // direct display memory write
  input  wire logic        dm_valid,
  input  wire logic [7:0]  dm_char,
  input  wire logic [7:0]  dm_attr,
  // character write to display memory
  output logic             chr_valid,
  output logic [7:0]       chr_code,
  output logic [7:0]       chr_attr,
  // active video mode
  output logic [7:0]       mode_active,
  // backlight control request
  input  wire logic        bl_valid,
  input  wire logic [15:0] bl_func,
  input  wire logic [7:0]  bl_sub,
  input  wire logic [7:0]  bl_sel,
  output logic             backlight_on,
  // keyboard indicators: 0 scroll, 1 num, 2 caps
  input  wire logic [2:0]  kbd_led_in,
  output logic [2:0]       kbd_led_out,
  // lcd pixel path, four codes per cycle
  input  wire logic [15:0] pix_codes,
  output logic [3:0]       pix_white,
  output logic             lcd_drive_en
);

  // reset synchroniser
  logic rst_meta_ff;   // first stage, read only by second
  logic rst_sync_n_ff; // released reset for the design

  // release through two flops, assert at once
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff   <= 1'b0;
      rst_sync_n_ff <= 1'b0;
    end else begin
      rst_meta_ff   <= 1'b1;
      rst_sync_n_ff <= rst_meta_ff;
    end
  end

  wire rst_n; // synchronised reset
  assign rst_n = rst_sync_n_ff;

  // state
  logic        cmap_en_ff;    // correction enable
  logic [7:0]  rdata_ff;      // read data
  logic        rvalid_ff;     // read answer
  logic        chr_valid_ff;  // char write strobe
  logic [7:0]  chr_code_ff;   // char code
  logic [7:0]  chr_attr_ff;   // char attribute
  logic [7:0]  mode_ff;       // active mode
  logic [2:0]  led_saved_ff;  // indicators at blanking
  logic [2:0]  led_out_ff;    // indicator drive
  logic [3:0]  pix_white_ff;  // pixel colour
  logic        drive_en_ff;   // display driven
  mono_pkg::bl_state_t bl_ff; // backlight state

  // mapper link
  attr_if am ();
  attr_mapper u_mapper (
    .m (am.mapper)
  );

  // decode
  wire pwr_hit;      // power register addressed
  wire pwr_rd;       // read of power register
  wire other_rd;     // read of unmapped address
  wire vsr_wchar;    // character write service
  wire vsr_setmode;  // mode set service
  wire bl_req;       // backlight control request
  wire bl_req_on;    // turn backlight on
  wire bl_req_off;   // turn backlight off
  wire led_none_lit; // no indicator lit now

  assign pwr_hit     = (io_addr == `PWR_STATUS_ADDR);
  assign pwr_rd      = io_rd && pwr_hit;
  assign other_rd    = io_rd && !pwr_hit;
  assign vsr_wchar   = vsr_valid &&
                       (vsr_func == `VSR_FN_WRITE_CHAR);
  assign vsr_setmode = vsr_valid &&
                       (vsr_func == `VSR_FN_SET_MODE);
  assign bl_req      = bl_valid && (bl_func == `BL_FUNC) &&
                       (bl_sub == `BL_SUB);
  assign bl_req_on   = bl_req && (bl_sel == `BL_SEL_ON);
  assign bl_req_off  = bl_req && (bl_sel == `BL_SEL_OFF);
  assign led_none_lit = (kbd_led_in == `LED_NONE);

  // mapper inputs
  assign am.cmap_en   = cmap_en_ff;
  assign am.attr_in   = vsr_attr;
  assign am.pix_codes = pix_codes;

  // next values
  wire [7:0] nxt_rdata;   // read answer byte
  wire [7:0] nxt_mode;    // remapped mode
  wire [7:0] nxt_code;    // chosen char
  wire [7:0] nxt_attr;    // chosen attribute
  wire [2:0] nxt_off_led; // indicators while dark

  // power register: bit 0 power, rest zero
  assign nxt_rdata = pwr_rd ?
                     {7'h00, primary_power} : 8'h00;

  // only mode 5 changes; other modes pass as asked
  assign nxt_mode = (vsr_mode == `MODE_COLOUR_GFX) ?
                    `MODE_MONO_GFX : vsr_mode;

  // service writes take the corrected attribute;
  // direct writes bypass the mapper entirely
  assign nxt_code = vsr_wchar ? vsr_char : dm_char;
  assign nxt_attr = vsr_wchar ? am.attr_out : dm_attr;

  // keep lit indicators, else light scroll as reminder
  assign nxt_off_led = led_none_lit ?
                       `LED_SCROLL : kbd_led_in;

  // i/o channel answers; writes to power register
  // have no effect at all
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= pwr_rd || other_rd;
    end
  end

  // option byte holds the correction enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmap_en_ff <= `CMAP_EN_RESET;
    end else if (opt_wr) begin
      cmap_en_ff <= opt_wdata[`OPT_CMAP_BIT];
    end
  end

  // active mode follows mode set requests
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff <= `MODE_RESET;
    end else if (vsr_setmode) begin
      mode_ff <= nxt_mode;
    end
  end

  // character write path; service write wins when
  // both arrive together, a direct write then is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      chr_valid_ff <= 1'b0;
      chr_code_ff  <= 8'h00;
      chr_attr_ff  <= 8'h00;
    end else begin
      chr_valid_ff <= vsr_wchar || dm_valid;
      if (vsr_wchar || dm_valid) begin
        chr_code_ff <= nxt_code;
        chr_attr_ff <= nxt_attr;
      end
    end
  end

  // backlight state machine
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bl_ff <= mono_pkg::BL_LIT;
    end else begin
      unique case (bl_ff)
        mono_pkg::BL_LIT: begin
          if (bl_req_off) begin
            bl_ff <= mono_pkg::BL_DARK;
          end
        end
        mono_pkg::BL_DARK: begin
          if (bl_req_on) begin
            bl_ff <= mono_pkg::BL_LIT;
          end
        end
        default: begin
          bl_ff <= mono_pkg::BL_LIT;
        end
      endcase
    end
  end

  // snapshot indicators at the moment of blanking
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      led_saved_ff <= `LED_NONE;
    end else if (bl_ff == mono_pkg::BL_LIT && bl_req_off) begin
      led_saved_ff <= kbd_led_in;
    end
  end

  // indicator drive: follow keyboard while lit,
  // reminder while dark, restore snapshot on relight
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      led_out_ff <= `LED_NONE;
    end else begin
      unique case (bl_ff)
        mono_pkg::BL_LIT: begin
          if (bl_req_off) begin
            led_out_ff <= nxt_off_led;
          end else begin
            led_out_ff <= kbd_led_in;
          end
        end
        mono_pkg::BL_DARK: begin
          if (bl_req_on) begin
            led_out_ff <= led_saved_ff;
          end
        end
        default: begin
          led_out_ff <= kbd_led_in;
        end
      endcase
    end
  end

  // pixel colour and display drive; the panel is
  // blanked on battery since it cannot run there
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pix_white_ff <= 4'h0;
      drive_en_ff  <= 1'b0;
    end else begin
      pix_white_ff <= primary_power ?
                      am.pix_white : 4'h0;
      drive_en_ff  <= primary_power;
    end
  end

  // outputs
  assign io_rdata     = rdata_ff;
  assign io_rvalid    = rvalid_ff;
  assign chr_valid    = chr_valid_ff;
  assign chr_code     = chr_code_ff;
  assign chr_attr     = chr_attr_ff;
  assign mode_active  = mode_ff;
  assign backlight_on = (bl_ff == mono_pkg::BL_LIT) &&
                        drive_en_ff;
  assign kbd_led_out  = led_out_ff;
  assign pix_white    = pix_white_ff;
  assign lcd_drive_en = drive_en_ff;

endmodule // mono_lcd_attribute_power_logic
`default_nettype wire

/* File: bench/mono_lcd_asserts.sv */
// port checks for the mono lcd logic
`timescale 1ns/100ps
`default_nettype none
module mono_lcd_asserts (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [15:0] io_addr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_rdata,
  input wire logic        io_rvalid,
  input wire logic        primary_power,
  input wire logic        vsr_valid,
  input wire logic [7:0]  vsr_func,
  input wire logic [7:0]  vsr_mode,
  input wire logic [7:0]  vsr_char,
  input wire logic        dm_valid,
  input wire logic [7:0]  dm_attr,
  input wire logic        chr_valid,
  input wire logic [7:0]  chr_code,
  input wire logic [7:0]  chr_attr,
  input wire logic [7:0]  mode_active,
  input wire logic        bl_valid,
  input wire logic [15:0] bl_func,
  input wire logic [7:0]  bl_sub,
  input wire logic [7:0]  bl_sel,
  input wire logic        backlight_on,
  input wire logic [2:0]  kbd_led_in,
  input wire logic [2:0]  kbd_led_out,
  input wire logic [15:0] pix_codes,
  input wire logic [3:0]  pix_white,
  input wire logic        lcd_drive_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // service char write wins over a direct write in the same cycle
  wire logic svc_wr = vsr_valid && vsr_func == 8'h09;
  // off request; gated by lit so a repeat while dark is not judged
  wire logic bl_off = bl_valid && bl_func == 16'h11ba
                      && bl_sub == 8'h03 && bl_sel == 8'h00;
  a_read_answer: assert property (io_rd |=> io_rvalid
    && io_rdata == ($past(io_addr) == 16'hf301 ?
       {7'h00, $past(primary_power)} : 8'h00)) else $error("bad read");
  a_read_quiet: assert property (!io_rd |=> !io_rvalid)
    else $error("stray read answer");
  a_mode_map: assert property (vsr_valid && vsr_func == 8'h00 |=>
    mode_active == ($past(vsr_mode) == 8'h05 ? 8'h04 : $past(vsr_mode)))
    else $error("bad mode remap");
  a_char_path: assert property (svc_wr |=> chr_valid
    && chr_code == $past(vsr_char)) else $error("char write lost");
  a_direct_pass: assert property (dm_valid && !svc_wr |=>
    chr_valid && chr_attr == $past(dm_attr)) else $error("direct altered");
  a_pix_parity: assert property ($past(primary_power) |->
    pix_white == {$past(pix_codes[12]), $past(pix_codes[8]),
                  $past(pix_codes[4]), $past(pix_codes[0])})
    else $error("bad pixel parity");
  a_batt_dark: assert property (!primary_power |=>
    pix_white == 4'h0 && !lcd_drive_en) else $error("driven on battery");
  a_bl_dark: assert property (bl_off && backlight_on |=>
    !backlight_on && kbd_led_out == ($past(kbd_led_in) != 3'h0 ?
    $past(kbd_led_in) : 3'h1)) else $error("bad backlight off");
endmodule // mono_lcd_asserts
bind mono_lcd_attribute_power_logic mono_lcd_asserts chk_i (.*);
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the mono lcd logic
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk_sys, reset_n, io_rd, io_wr, primary_power, opt_wr;
  logic vsr_valid, dm_valid, bl_valid, chr_valid, io_rvalid;
  logic backlight_on, lcd_drive_en, en;
  logic [15:0] io_addr, bl_func, pix_codes, c;
  logic [7:0]  io_wdata, io_rdata, opt_wdata, vsr_func, vsr_mode, a;
  logic [7:0]  vsr_char, vsr_attr, dm_char, dm_attr, chr_code;
  logic [7:0]  chr_attr, mode_active, bl_sub, bl_sel;
  logic [2:0]  kbd_led_in, kbd_led_out;
  logic [3:0]  pix_white;
  int          n_mismatch, checked;
  // modes asked for; colour graphics 5 must come back as 4
  logic [7:0]  modes [7] = '{8'h00, 8'h02, 8'h04, 8'h05, 8'h06,
                             8'h0b, 8'h0d};
  mono_lcd_attribute_power_logic dut (.*);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // expected attribute: flip fg bit 0 when fg and bg parity agree
  function automatic logic [7:0] fix(logic [7:0] t, logic e);
    return (e && t[0] == t[4]) ? t ^ 8'h01 : t;
  endfunction
  task chk(string s, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", s, exp, seen);
    end
  endtask
  // hold the request one edge, drop strobes, let outputs settle
  task fire;
    @(posedge clk_sys);
    {io_rd, io_wr, opt_wr, vsr_valid, dm_valid, bl_valid} <= 6'h00;
    #1;
  endtask
  task io(logic w, logic [15:0] ad);
    @(posedge clk_sys);
    io_rd <= !w;
    io_wr <= w;
    io_addr <= ad;
    io_wdata <= 8'hff;
    fire;
  endtask
  task svc(logic [7:0] f, logic [7:0] d, logic [7:0] t);
    @(posedge clk_sys);
    vsr_valid <= 1'b1;
    vsr_func <= f;
    vsr_mode <= d;
    vsr_char <= d;
    vsr_attr <= t;
    fire;
  endtask
  task bl(logic [7:0] s, logic [2:0] l);
    @(posedge clk_sys);
    bl_valid <= 1'b1;
    bl_func <= 16'h11ba;
    bl_sub <= 8'h03;
    bl_sel <= s;
    kbd_led_in <= l;
    fire;
  endtask
  task wrap_up;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a hang counts as a mismatch and ends the run
  initial begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    {io_rd, io_wr, opt_wr, vsr_valid, dm_valid, bl_valid} = 6'h00;
    {io_addr, bl_func, pix_codes, io_wdata, opt_wdata, vsr_func} = '0;
    {vsr_mode, vsr_char, vsr_attr, dm_char, dm_attr, bl_sub} = '0;
    {bl_sel, kbd_led_in} = '0;
    reset_n = 1'b0;
    primary_power = 1'b1;
    void'($urandom(39946));
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // writes ignored, hole reads zero, power loss seen
    io(1'b1, 16'hf301);
    io(1'b0, 16'hf301);
    chk("rvalid", io_rvalid, 1'b1);
    chk("pwr", io_rdata, 8'h01);
    io(1'b0, 16'hf300);
    chk("hole", io_rdata, 8'h00);
    primary_power <= 1'b0;
    pix_codes <= 16'hffff;
    io(1'b0, 16'hf301);
    chk("pwr", io_rdata, 8'h00);
    chk("pix", pix_white, 4'h0);
    chk("drive", lcd_drive_en, 1'b0);
    chk("bl", backlight_on, 1'b0);
    primary_power <= 1'b1;
    $display("test power done");
    foreach (modes[i]) begin
      svc(8'h00, modes[i], 8'h00);
      chk("mode", mode_active, modes[i] == 8'h05 ? 8'h04 : modes[i]);
      chk("valid", chr_valid, 1'b0);
    end
    chk("drive", lcd_drive_en, 1'b1);
    $display("test modes done");
    // pass 0 default on, pass 1 cleared, pass 2 set via bit 2
    en = 1'b1;
    for (int k = 0; k < 3; k++) begin
      if (k > 0) begin
        en = (k == 2);
        @(posedge clk_sys);
        opt_wr <= 1'b1;
        opt_wdata <= {5'h00, en, 2'h3};
        fire;
      end
      for (int i = 0; i < 20; i++) begin
        a = i == 0 ? 8'h17 : i == 1 ? 8'h00 : 8'($urandom);
        c = 16'($urandom);
        svc(8'h09, c[7:0], a);
        chk("attr", chr_attr, fix(a, en));
        chk("code", chr_code, c[7:0]);
        chk("valid", chr_valid, 1'b1);
        @(posedge clk_sys);
        dm_valid <= 1'b1;
        dm_attr <= a;
        fire;
        chk("direct", chr_attr, a);
        chk("valid", chr_valid, 1'b1);
      end
    end
    $display("test correction done");
    for (int i = 0; i < 30; i++) begin
      c = 16'($urandom);
      @(posedge clk_sys);
      pix_codes <= c;
      fire;
      chk("pix", pix_white, {c[12], c[8], c[4], c[0]});
    end
    $display("test pixels done");
    // dark with none lit, repeat ignored, restore, then a lit case
    bl(8'h00, 3'h0);
    chk("bl", backlight_on, 1'b0);
    chk("led", kbd_led_out, 3'h1);
    bl(8'h00, 3'h4);
    chk("led", kbd_led_out, 3'h1);
    bl(8'h01, 3'h4);
    chk("bl", backlight_on, 1'b1);
    chk("led", kbd_led_out, 3'h0);
    bl(8'h00, 3'h6);
    chk("led", kbd_led_out, 3'h6);
    bl(8'h01, 3'h0);
    chk("led", kbd_led_out, 3'h6);
    $display("test backlight done");
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
